// [src/aod_decoder.v]
/*
 Arithmetic opcode decoder: takes instruction bytes one per strobe and
 reports the decoded arithmetic operation, operand width, direction,
 sign-extend, register field and the count of immediate bytes.
 Assumes the fetch path offers bytes in program order on the same clock,
 and pulses restart_i at each instruction boundary it wants to resync on.
*/
// Overview of operation
// RULE1: Add decoded as reg/mem-reg, immediate group field 000, accumulator-immediate.
// RULE2: Add-with-carry decoded as 000100dw, immediate group field 010, or 0001010w.
// RULE3: Increment is 1111111w field 000, or one byte 01000 plus register.
// RULE4: Byte 00110111 decodes as the unpacked-decimal fixup after addition.
// RULE5: Byte 00100111 decodes as the packed-decimal fixup after addition.
// RULE6: Subtract decoded as 001010dw, immediate group field 101, or 0010110w.
// RULE7: Subtract-with-borrow as 000110dw, immediate group field 011, or 0001110w.
// RULE8: Decrement is 1111111w field 001, or one byte 01001 plus register.
// RULE9: Sign change is 1111011w with second-byte field 011.
// RULE10: Compare as 001110dw, group field 111, 0011110w; same extra-byte rule.
// RULE11: Byte 00101111 decodes as the packed-decimal fixup after subtraction.
// RULE12: 1111011w with field 100 decodes as unsigned multiply.
// RULE13: 1111011w with field 101 decodes as signed multiply.
// RULE14: Bytes 11010100 then 00001010 decode as multiply fixup.
// RULE15: 1111011w field 110 is unsigned divide, field 111 signed divide.
// RULE16: Bytes 11010101 then 00001010 decode as the pre-divide fixup.
// RULE17: Byte 10011000 decodes as byte-to-word sign extension.
// RULE18: Byte 10011001 decodes as word-to-double-word sign extension.
// RULE19: w set means word, d set means reg is destination, s extends immediate.
`timescale 1ns/1ns
`include "aod_map.vh"

module aod_decoder
(
   input wire clk_i,
   input wire rst_n_i,
   input wire byte_valid_i,
   input wire [7:0] byte_i,
   input wire restart_i,
   output wire need_second_o,
   output reg done_o,
   output reg [4:0] op_o,
   output reg word_o,
   output reg reg_dest_o,
   output reg sign_ext_o,
   output reg [2:0] reg_field_o,
   output reg [1:0] imm_bytes_o,
   output reg has_modrm_o
);

   ////////////////////////////////////////////////////////////////////////
   // States, one-hot
   localparam [1:0] ST_FIRST = 2'b01;
   localparam [1:0] ST_SECOND = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] first_q;
   reg [7:0] first_d;

   // Immediate bytes for the 100000sw group: two only when s:w reads 01
   function [1:0] grp_imm;
      input [7:0] b;
      begin
         if (!b[`AOD_S_BIT] && b[`AOD_W_BIT]) // [RULE1] [RULE10]
         begin
            grp_imm = 2'h2;
         end
         else
         begin
            grp_imm = 2'h1;
         end
      end
   endfunction

   // Immediate bytes for accumulator forms: two when word width
   function [1:0] acc_imm;
      input [7:0] b;
      begin
         acc_imm = b[`AOD_W_BIT] ? 2'h2 : 2'h1; // [RULE19]
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // First-byte classification
   reg [4:0] f_op;
   reg f_two;
   reg f_modrm;
   reg [1:0] f_imm;

   // One-byte forms finish here; others ask for a second byte
   always @*
   begin
      f_op = `AOD_OP_BAD;
      f_two = 1'b0;
      f_modrm = 1'b0;
      f_imm = 2'h0;
      if (byte_i[7:2] == `AOD_SUM_RM)
      begin
         f_op = `AOD_OP_SUM; // [RULE1]
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:2] == `AOD_CARRY_RM)
      begin
         f_op = `AOD_OP_CARRY; // [RULE2]
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:2] == `AOD_DIFF_RM)
      begin
         f_op = `AOD_OP_DIFF; // [RULE6]
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:2] == `AOD_BORROW_RM)
      begin
         f_op = `AOD_OP_BORROW; // [RULE7]
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:2] == `AOD_CMP_RM)
      begin
         f_op = `AOD_OP_CMP; // [RULE10]
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:2] == `AOD_IMM_GRP || byte_i[7:1] == `AOD_UNARY_GRP ||
         byte_i[7:1] == `AOD_MULDIV_GRP || byte_i == `AOD_PROD_FIX ||
         byte_i == `AOD_QUOT_FIX)
      begin
         // Operation depends on the second byte's middle field, or on the whole byte for the pair fixups
         f_op = `AOD_OP_NONE;
         f_two = 1'b1;
         f_modrm = 1'b1;
      end
      else if (byte_i[7:1] == `AOD_SUM_ACC)
      begin
         f_op = `AOD_OP_SUM; // [RULE1]
         f_imm = acc_imm(byte_i);
      end
      else if (byte_i[7:1] == `AOD_CARRY_ACC)
      begin
         f_op = `AOD_OP_CARRY; // [RULE2]
         f_imm = acc_imm(byte_i);
      end
      else if (byte_i[7:1] == `AOD_DIFF_ACC)
      begin
         f_op = `AOD_OP_DIFF; // [RULE6]
         f_imm = acc_imm(byte_i);
      end
      else if (byte_i[7:1] == `AOD_BORROW_ACC)
      begin
         f_op = `AOD_OP_BORROW; // [RULE7]
         f_imm = acc_imm(byte_i);
      end
      else if (byte_i[7:1] == `AOD_CMP_ACC)
      begin
         f_op = `AOD_OP_CMP; // [RULE10]
         f_imm = acc_imm(byte_i);
      end
      else if (byte_i[7:3] == `AOD_INC_REG)
      begin
         f_op = `AOD_OP_UP; // [RULE3]
      end
      else if (byte_i[7:3] == `AOD_DEC_REG)
      begin
         f_op = `AOD_OP_DOWN; // [RULE8]
      end
      else if (byte_i == `AOD_ASCII_ADD)
      begin
         f_op = `AOD_OP_ASCII_ADD; // [RULE4]
      end
      else if (byte_i == `AOD_BCD_ADD)
      begin
         f_op = `AOD_OP_BCD_ADD; // [RULE5]
      end
      else if (byte_i == `AOD_ASCII_SUB)
      begin
         f_op = `AOD_OP_ASCII_SUB;
      end
      else if (byte_i == `AOD_BCD_SUB)
      begin
         f_op = `AOD_OP_BCD_SUB; // [RULE11]
      end
      else if (byte_i == `AOD_EXT_BW)
      begin
         f_op = `AOD_OP_EXT_BW; // [RULE17]
      end
      else if (byte_i == `AOD_EXT_WD)
      begin
         f_op = `AOD_OP_EXT_WD; // [RULE18]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Second-byte classification, against the held first byte
   reg [4:0] s_op;
   reg [1:0] s_imm;
   wire [2:0] mid = byte_i[`AOD_MID_HI:`AOD_MID_LO];

   always @*
   begin
      s_op = `AOD_OP_BAD;
      s_imm = 2'h0;
      if (first_q[7:2] == `AOD_IMM_GRP)
      begin
         s_imm = grp_imm(first_q);
         case (mid)
            `AOD_MID_000: s_op = `AOD_OP_SUM; // [RULE1]
            `AOD_MID_010: s_op = `AOD_OP_CARRY; // [RULE2]
            `AOD_MID_101: s_op = `AOD_OP_DIFF; // [RULE6]
            `AOD_MID_011: s_op = `AOD_OP_BORROW; // [RULE7]
            `AOD_MID_111: s_op = `AOD_OP_CMP; // [RULE10]
            default: s_op = `AOD_OP_BAD; // Logic ops, not this group
         endcase
      end
      else if (first_q[7:1] == `AOD_UNARY_GRP)
      begin
         case (mid)
            `AOD_MID_000: s_op = `AOD_OP_UP; // [RULE3]
            `AOD_MID_001: s_op = `AOD_OP_DOWN; // [RULE8]
            default: s_op = `AOD_OP_BAD;
         endcase
      end
      else if (first_q[7:1] == `AOD_MULDIV_GRP)
      begin
         case (mid)
            `AOD_MID_011: s_op = `AOD_OP_FLIP; // [RULE9]
            `AOD_MID_100: s_op = `AOD_OP_UMUL; // [RULE12]
            `AOD_MID_101: s_op = `AOD_OP_SMUL; // [RULE13]
            `AOD_MID_110: s_op = `AOD_OP_UDIV; // [RULE15]
            `AOD_MID_111: s_op = `AOD_OP_SDIV; // [RULE15]
            default: s_op = `AOD_OP_BAD;
         endcase
      end
      else if (first_q == `AOD_PROD_FIX && byte_i == `AOD_FIX_TAIL)
      begin
         s_op = `AOD_OP_PROD_FIX; // [RULE14]
      end
      else if (first_q == `AOD_QUOT_FIX && byte_i == `AOD_FIX_TAIL)
      begin
         s_op = `AOD_OP_QUOT_FIX; // [RULE16]
      end
      else if (first_q[7:2] == `AOD_SUM_RM || first_q[7:2] == `AOD_CARRY_RM ||
         first_q[7:2] == `AOD_DIFF_RM || first_q[7:2] == `AOD_BORROW_RM ||
         first_q[7:2] == `AOD_CMP_RM)
      begin
         s_op = f_op_of(first_q);
      end
   end

   // Op of a reg/mem-with-register first byte
   function [4:0] f_op_of;
      input [7:0] b;
      begin
         case (b[7:2])
            `AOD_SUM_RM: f_op_of = `AOD_OP_SUM;
            `AOD_CARRY_RM: f_op_of = `AOD_OP_CARRY;
            `AOD_DIFF_RM: f_op_of = `AOD_OP_DIFF;
            `AOD_BORROW_RM: f_op_of = `AOD_OP_BORROW;
            `AOD_CMP_RM: f_op_of = `AOD_OP_CMP;
            default: f_op_of = `AOD_OP_BAD;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and result registers
   assign need_second_o = (state_q == ST_SECOND);

   always @*
   begin
      state_d = state_q;
      first_d = first_q;
      case (state_q)
         ST_FIRST:
         begin
            if (byte_valid_i && f_two)
            begin
               state_d = ST_SECOND;
               first_d = byte_i;
            end
         end
         ST_SECOND:
         begin
            if (byte_valid_i)
            begin
               state_d = ST_FIRST;
            end
         end
         default: state_d = ST_FIRST;
      endcase
      if (restart_i)
      begin
         state_d = ST_FIRST;
      end
   end

   // Results load when an instruction completes; done is a pulse
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_FIRST;
         first_q <= `AOD_RST_BYTE;
         done_o <= 1'b0;
         op_o <= `AOD_RST_OP;
         word_o <= 1'b0;
         reg_dest_o <= 1'b0;
         sign_ext_o <= 1'b0;
         reg_field_o <= 3'h0;
         imm_bytes_o <= 2'h0;
         has_modrm_o <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         first_q <= first_d;
         done_o <= 1'b0;
         if (byte_valid_i && !restart_i && state_q == ST_FIRST && !f_two)
         begin
            done_o <= 1'b1;
            op_o <= f_op;
            word_o <= byte_i[`AOD_W_BIT] | (byte_i[7:3] == `AOD_INC_REG) |
               (byte_i[7:3] == `AOD_DEC_REG); // [RULE19]
            reg_dest_o <= 1'b0;
            sign_ext_o <= 1'b0;
            reg_field_o <= byte_i[2:0]; // [RULE3] [RULE8]
            imm_bytes_o <= f_imm;
            has_modrm_o <= 1'b0;
         end
         else if (byte_valid_i && !restart_i && state_q == ST_SECOND)
         begin
            done_o <= 1'b1;
            op_o <= s_op;
            word_o <= first_q[`AOD_W_BIT]; // [RULE19]
            // Direction only exists on reg/mem-with-register forms
            reg_dest_o <= first_q[`AOD_D_BIT] && !first_q[7]; // [RULE19]
            sign_ext_o <= (first_q[7:2] == `AOD_IMM_GRP) && first_q[`AOD_S_BIT];
            reg_field_o <= mid;
            imm_bytes_o <= s_imm;
            has_modrm_o <= (first_q != `AOD_PROD_FIX) && (first_q != `AOD_QUOT_FIX);
         end
      end
   end

endmodule

// [src/aod_map.vh]
/*
 Constants for the arithmetic opcode decoder: opcode patterns, field
 positions, operation codes and reset values. Included by the decoder.
*/
`ifndef AOD_MAP_VH
`define AOD_MAP_VH

// Field positions in the first and second byte
`define AOD_W_BIT 0
`define AOD_D_BIT 1
`define AOD_S_BIT 1
`define AOD_MID_HI 5
`define AOD_MID_LO 3
`define AOD_MOD_HI 7
`define AOD_MOD_LO 6

// First-byte patterns, upper six bits for the d/w forms and the s/w immediate group
`define AOD_SUM_RM 6'h00
`define AOD_CARRY_RM 6'h04
`define AOD_DIFF_RM 6'h0a
`define AOD_BORROW_RM 6'h06
`define AOD_CMP_RM 6'h0e
`define AOD_IMM_GRP 6'h20
// Upper seven bits for accumulator-immediate forms and the unary and multiply/divide groups
`define AOD_SUM_ACC 7'h02
`define AOD_CARRY_ACC 7'h0a
`define AOD_DIFF_ACC 7'h16
`define AOD_BORROW_ACC 7'h0e
`define AOD_CMP_ACC 7'h1e
`define AOD_UNARY_GRP 7'h7f
`define AOD_MULDIV_GRP 7'h7b
// Upper five bits for one-byte register forms
`define AOD_INC_REG 5'h08
`define AOD_DEC_REG 5'h09
// Whole single bytes
`define AOD_ASCII_ADD 8'h37
`define AOD_BCD_ADD 8'h27
`define AOD_ASCII_SUB 8'h3f
`define AOD_BCD_SUB 8'h2f
`define AOD_PROD_FIX 8'hd4
`define AOD_QUOT_FIX 8'hd5
`define AOD_FIX_TAIL 8'h0a
`define AOD_EXT_BW 8'h98
`define AOD_EXT_WD 8'h99

// Middle-field codes
`define AOD_MID_000 3'h0
`define AOD_MID_001 3'h1
`define AOD_MID_010 3'h2
`define AOD_MID_011 3'h3
`define AOD_MID_100 3'h4
`define AOD_MID_101 3'h5
`define AOD_MID_110 3'h6
`define AOD_MID_111 3'h7

// Operation codes on op_o
`define AOD_OP_NONE 5'h00
`define AOD_OP_SUM 5'h01
`define AOD_OP_CARRY 5'h02
`define AOD_OP_UP 5'h03
`define AOD_OP_ASCII_ADD 5'h04
`define AOD_OP_BCD_ADD 5'h05
`define AOD_OP_DIFF 5'h06
`define AOD_OP_BORROW 5'h07
`define AOD_OP_DOWN 5'h08
`define AOD_OP_FLIP 5'h09
`define AOD_OP_CMP 5'h0a
`define AOD_OP_BCD_SUB 5'h0b
`define AOD_OP_UMUL 5'h0c
`define AOD_OP_SMUL 5'h0d
`define AOD_OP_PROD_FIX 5'h0e
`define AOD_OP_UDIV 5'h0f
`define AOD_OP_SDIV 5'h10
`define AOD_OP_QUOT_FIX 5'h11
`define AOD_OP_EXT_BW 5'h12
`define AOD_OP_EXT_WD 5'h13
`define AOD_OP_ASCII_SUB 5'h14
`define AOD_OP_BAD 5'h1f

// Reset values
`define AOD_RST_OP 5'h00
`define AOD_RST_BYTE 8'h00

`endif

// [tb/aod_decoder_checker.sv]
/* Port assertions for the arithmetic opcode decoder.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ns
module aod_decoder_checker
(
   input wire clk_i,
   input wire rst_n_i,
   input wire byte_valid_i,
   input wire [7:0] byte_i,
   input wire restart_i,
   input wire need_second_o,
   input wire done_o,
   input wire [4:0] op_o,
   input wire word_o,
   input wire reg_dest_o,
   input wire sign_ext_o,
   input wire [2:0] reg_field_o,
   input wire [1:0] imm_bytes_o,
   input wire has_modrm_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
////////////////////////////////
// A first byte is taken only when nothing is half decoded
wire take_first = byte_valid_i && !restart_i && !need_second_o;
a_ascii_sum: assert property (take_first && byte_i == 8'h37 |=> done_o && op_o == 5'h04)
   else $error("ascii add fixup misdecoded");
a_bcd_sum: assert property (take_first && byte_i == 8'h27 |=> done_o && op_o == 5'h05)
   else $error("bcd add fixup misdecoded");
a_bcd_diff: assert property (take_first && byte_i == 8'h2f |=> done_o && op_o == 5'h0b)
   else $error("bcd subtract fixup misdecoded");
a_extend_ops: assert property (take_first && byte_i[7:1] == 7'h4c |=>
   done_o && op_o == ($past(byte_i[0]) ? 5'h13 : 5'h12)) else $error("extend misdecoded");
a_acc_sum_imm: assert property (take_first && byte_i[7:1] == 7'h02 |=> done_o &&
   op_o == 5'h01 && imm_bytes_o == ($past(byte_i[0]) ? 2'h2 : 2'h1)) else $error("acc add bad");
a_count_reg: assert property (take_first && byte_i[7:4] == 4'h4 |=> done_o &&
   op_o == ($past(byte_i[3]) ? 5'h08 : 5'h03) && reg_field_o == $past(byte_i[2:0]))
   else $error("register count misdecoded");
a_muldiv_wait: assert property (take_first && byte_i[7:1] == 7'h7b |=>
   need_second_o && !done_o) else $error("group byte did not wait");
a_second_done: assert property (need_second_o && byte_valid_i && !restart_i |=>
   done_o && !need_second_o) else $error("second byte not completed");
// Main paths worth seeing at least once
c_pair_fixup: cover property (take_first && byte_i == 8'hd4);
c_restart: cover property (restart_i && need_second_o);
c_unknown: cover property (done_o && op_o == 5'h1f);
endmodule
bind aod_decoder aod_decoder_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .byte_valid_i(byte_valid_i), .byte_i(byte_i), .restart_i(restart_i),
   .need_second_o(need_second_o), .done_o(done_o), .op_o(op_o), .word_o(word_o),
   .reg_dest_o(reg_dest_o), .sign_ext_o(sign_ext_o), .reg_field_o(reg_field_o),
   .imm_bytes_o(imm_bytes_o), .has_modrm_o(has_modrm_o));

// [tb/aod_decoder_tb.sv]
/* Self-checking bench for the arithmetic opcode decoder.
   Assumes the decoder ports as declared and a 100 MHz clock. */
`timescale 1ns/1ns
module aod_decoder_tb;
reg clk_i, rst_n_i, fetch_req, restart;
reg [7:0] fetch_data;
wire byte_valid, need_second, done, word, dest, sext, modrm;
wire [7:0] fbyte;
wire [4:0] op;
wire [2:0] rfield;
wire [1:0] imm;
integer n_mismatch, comparisons, cycles;
aod_fetch_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(fetch_req),
   .data_i(fetch_data), .byte_valid_o(byte_valid), .byte_o(fbyte));
aod_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid),
   .byte_i(fbyte), .restart_i(restart), .need_second_o(need_second), .done_o(done),
   .op_o(op), .word_o(word), .reg_dest_o(dest), .sign_ext_o(sext),
   .reg_field_o(rfield), .imm_bytes_o(imm), .has_modrm_o(modrm));
////////////////////////////////
initial
begin
   clk_i = 1'h0;
   forever #5 clk_i = ~clk_i;
end
task check(input [9:0] seen, input [9:0] exp);
begin
   comparisons = comparisons + 1;
   if (seen !== exp)
   begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
   end
end
endtask
// Mode bit 1 sends a second byte, bit 0 judges width and direction too
task run(input [1:0] m, input [7:0] b0, input [7:0] b1, input [9:0] e);
begin
   @(posedge clk_i);
   fetch_req <= 1'h1;
   fetch_data <= b0;
   if (m[1])
   begin
      @(posedge clk_i);
      fetch_data <= b1;
   end
   @(posedge clk_i);
   fetch_req <= 1'h0;
   @(posedge clk_i);
   #1;
   check({9'h000, done}, 10'h001);
   if (m[0])
      check({op, imm, word, dest, sext}, e);
   else
      check({op, imm, 3'h0}, {e[9:3], 3'h0});
   // Pair fixups carry no mod/reg/rm byte; one-byte forms report their low bits
   check({6'h00, modrm, rfield},
      {6'h00, m[1] && b0[7:1] != 7'h6a, m[1] ? b1[5:3] : b0[2:0]});
end
endtask
task scen_single;
begin
   run(2'h0, 8'h37, 8'h00, {5'h04, 5'h00});
   run(2'h0, 8'h27, 8'h00, {5'h05, 5'h00});
   run(2'h0, 8'h2f, 8'h00, {5'h0b, 5'h00});
   run(2'h0, 8'h3f, 8'h00, {5'h14, 5'h00});
   run(2'h0, 8'h98, 8'h00, {5'h12, 5'h00});
   run(2'h0, 8'h99, 8'h00, {5'h13, 5'h00});
   run(2'h1, 8'h04, 8'h00, {5'h01, 5'h08});
   run(2'h1, 8'h05, 8'h00, {5'h01, 5'h14});
   run(2'h1, 8'h15, 8'h00, {5'h02, 5'h14});
   run(2'h1, 8'h2c, 8'h00, {5'h06, 5'h08});
   run(2'h1, 8'h1d, 8'h00, {5'h07, 5'h14});
   run(2'h1, 8'h3d, 8'h00, {5'h0a, 5'h14});
   run(2'h1, 8'h43, 8'h00, {5'h03, 5'h04});
   run(2'h1, 8'h4e, 8'h00, {5'h08, 5'h04});
end
endtask
task scen_two_byte;
begin
   run(2'h3, 8'h01, 8'hc0, {5'h01, 5'h04});
   run(2'h3, 8'h12, 8'hc0, {5'h02, 5'h02});
   run(2'h3, 8'h2b, 8'hc0, {5'h06, 5'h06});
   run(2'h3, 8'h18, 8'hc0, {5'h07, 5'h00});
   run(2'h3, 8'h3b, 8'hc0, {5'h0a, 5'h06});
   run(2'h3, 8'h80, 8'h00, {5'h01, 5'h08});
   run(2'h3, 8'h81, 8'h10, {5'h02, 5'h14});
   run(2'h3, 8'h83, 8'he8, {5'h06, 5'h0d});
   run(2'h3, 8'h82, 8'h18, {5'h07, 5'h09});
   run(2'h3, 8'h83, 8'h38, {5'h0a, 5'h0d});
   run(2'h3, 8'hff, 8'h00, {5'h03, 5'h04});
   run(2'h3, 8'hfe, 8'h08, {5'h08, 5'h00});
   run(2'h3, 8'hf7, 8'h18, {5'h09, 5'h04});
   run(2'h3, 8'hf6, 8'h20, {5'h0c, 5'h00});
   run(2'h3, 8'hf7, 8'h28, {5'h0d, 5'h04});
   run(2'h3, 8'hf6, 8'h30, {5'h0f, 5'h00});
   run(2'h3, 8'hf7, 8'h38, {5'h10, 5'h04});
   run(2'h2, 8'hd4, 8'h0a, {5'h0e, 5'h00});
   run(2'h2, 8'hd5, 8'h0a, {5'h11, 5'h00});
   run(2'h2, 8'hd4, 8'h0b, {5'h1f, 5'h00});
end
endtask
// A restart drops a half-decoded group byte and the byte offered with it
task scen_restart;
begin
   @(posedge clk_i);
   fetch_req <= 1'h1;
   fetch_data <= 8'hf7;
   @(posedge clk_i);
   fetch_data <= 8'h28;
   @(posedge clk_i);
   fetch_req <= 1'h0;
   restart <= 1'h1;
   @(posedge clk_i);
   restart <= 1'h0;
   #1;
   check({8'h00, done, need_second}, 10'h000);
   run(2'h0, 8'h37, 8'h00, {5'h04, 5'h00});
end
endtask
task finish_test;
begin
   $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
   if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
   else
      $display("Regression broken");
   $finish;
end
endtask
// Hang guard: the whole run needs about 130 cycles
always @(posedge clk_i)
begin
   cycles = cycles + 1;
   if (cycles == 1000)
   begin
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
end
initial
begin
   rst_n_i = 1'h0;
   fetch_req = 1'h0;
   restart = 1'h0;
   fetch_data = 8'h00;
   n_mismatch = 0;
   comparisons = 0;
   cycles = 0;
   repeat (3) @(posedge clk_i);
   rst_n_i <= 1'h1;
   #1;
   check({op, imm, word, dest, sext}, 10'h000);
   scen_single;
   scen_two_byte;
   scen_restart;
   finish_test;
end
endmodule

// [tb/aod_fetch_model.sv]
/* Fetch path model: presents one program byte a cycle after each request.
   Assumes requests are changed by the bench just after a rising edge. */
`timescale 1ns/1ns
module aod_fetch_model
(
   input wire clk_i,
   input wire rst_n_i,
   input wire req_i,
   input wire [7:0] data_i,
   output reg byte_valid_o,
   output reg [7:0] byte_o
);
////////////////////////////////
initial byte_valid_o = 1'h0;
initial byte_o = 8'h00;
// Idle bus inverts every bit of the byte each cycle so stale data never passes as fresh
always @(posedge clk_i)
begin
   byte_valid_o <= rst_n_i && req_i;
   byte_o <= req_i ? data_i : ~byte_o;
end
endmodule
